// ===== rtl/rfc_consts.svh
// Widths, channel count and timing constants of the reciprocal frequency counter
`ifndef RFC_CONSTS_SVH
`define RFC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Widths and channel count
// ----------------------------------------------------------------------------
`define RFC_CYC_W          12
`define RFC_REF_W          20
`define RFC_GT_W           24
`define RFC_CHAN_N         4
`define RFC_SEL_W          2

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RFC_CLK_PERIOD_NS  10
`define RFC_GATE_TIME_NS   125000000
`define RFC_REF_FREQ_HZ    2097000

`endif

// ===== rtl/rfc_pkg.sv
// Types shared by the reciprocal frequency counter files
package rfc_pkg;

  typedef enum logic [1:0] {
    RFC_IDLE = 2'b00,
    RFC_ARM  = 2'b01,
    RFC_GATE = 2'b11,
    RFC_HOLD = 2'b10
  } rfc_state_t;

  typedef enum logic {
    RFC_SRC_SENSOR = 1'b0,
    RFC_SRC_RTC    = 1'b1
  } rfc_src_t;

endpackage

// ===== rtl/rfc_edge_counter.sv
// Rising-edge counter with synchronous clear and count enable
`timescale 1ns/1ps
module rfc_edge_counter #(
  parameter int unsigned W = 12
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         sigIn,
  input  wire logic         clear,
  input  wire logic         enable,
  output logic [W-1:0]      count,
  output logic              rise
);
  import rfc_pkg::*;

  logic         sigPrev;
  logic [W-1:0] next_count;

  assign rise       = sigIn & ~sigPrev;
  // Wraps silently; the reader is expected to size the gate to the input range
  assign next_count = clear ? '0 : ((enable && rise) ? W'(count + 1'b1) : count);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sigPrev <= 1'b0;
      count   <= '0;
    end else begin
      sigPrev <= sigIn;
      count   <= next_count;
    end
  end

endmodule

// ===== rtl/rfc_freq_counter.sv
// Reciprocal frequency counter: gated input-cycle and reference-cycle counts
`timescale 1ns/1ps
`include "rfc_consts.svh"
module rfc_freq_counter #(
  parameter int unsigned GATE_CYCLES = `RFC_GATE_TIME_NS / `RFC_CLK_PERIOD_NS
) (
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  input  wire logic [`RFC_CHAN_N-1:0]   sensorOsc,
  input  wire logic                     rtcOsc,
  input  wire logic                     refOsc,
  input  wire logic [`RFC_SEL_W-1:0]    chanSel,
  input  wire rfc_pkg::rfc_src_t        srcSel,
  input  wire logic                     startReq,
  input  wire logic                     readAck,
  output logic [`RFC_CYC_W-1:0]         cycleCount,
  output logic [`RFC_REF_W-1:0]         refCount,
  output logic                          measBusy,
  output logic                          measDone,
  output logic [`RFC_SEL_W-1:0]         activeChan,
  output rfc_pkg::rfc_src_t             activeSrc
);
  import rfc_pkg::*;

  localparam logic [`RFC_GT_W-1:0] GATE_LAST = `RFC_GT_W'(GATE_CYCLES - 1);

  rfc_state_t               state;
  rfc_state_t               next_state;
  logic [`RFC_GT_W-1:0]     gateTimer;
  logic [`RFC_GT_W-1:0]     next_gateTimer;
  logic                     selOsc;
  logic                     cycRise;
  logic                     refRise;
  logic                     startAccept;
  logic                     gateOpen;
  logic                     gateExpired;
  logic                     gateClose;
  logic                     inGate;
  logic                     armSettled;
  logic                     busyNext;
  logic                     doneNext;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Busy spans arming as well as gating, so a stopped input shows as busy
  function automatic logic is_busy(input rfc_state_t s);
    return (s == RFC_ARM) || (s == RFC_GATE);
  endfunction

  // --------------------------------------------------------------------------
  // Input selection and sequencing
  // --------------------------------------------------------------------------
  assign selOsc      = (activeSrc == RFC_SRC_RTC) ? rtcOsc : sensorOsc[activeChan];
  assign startAccept = (state == RFC_IDLE) && startReq;
  assign inGate      = (state == RFC_GATE);
  // Gate opens on an input edge so the first counted cycle is a whole one; the first
  // armed cycle is skipped because the edge detector's previous sample still holds
  // the input that was selected before the start
  assign gateOpen    = (state == RFC_ARM) && armSettled && cycRise;
  assign gateExpired = (gateTimer == GATE_LAST);
  // Closing on an input edge makes the gate an exact number of input cycles
  assign gateClose   = inGate && gateExpired && cycRise;
  assign next_gateTimer = !inGate ? '0 :
                          (gateExpired ? gateTimer : `RFC_GT_W'(gateTimer + 1'b1));
  assign busyNext    = is_busy(next_state);
  assign doneNext    = (next_state == RFC_HOLD);

  always_comb begin
    next_state = state;
    unique case (state)
      RFC_IDLE: if (startReq) next_state = RFC_ARM;
      RFC_ARM:  if (gateOpen) next_state = RFC_GATE;
      RFC_GATE: if (gateClose) next_state = RFC_HOLD;
      RFC_HOLD: if (readAck) next_state = RFC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= RFC_IDLE;
      gateTimer  <= '0;
      armSettled <= 1'b0;
    end else begin
      state      <= next_state;
      gateTimer  <= next_gateTimer;
      armSettled <= (state == RFC_ARM);
    end
  end

  // --------------------------------------------------------------------------
  // Status and latched selection
  // --------------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      measBusy <= 1'b0;
      measDone <= 1'b0;
    end else begin
      measBusy <= busyNext;
      measDone <= doneNext;
    end
  end

  // Latched at start so a select changed mid-gate cannot split a count
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      activeChan <= '0;
      activeSrc  <= RFC_SRC_SENSOR;
    end else if (startAccept) begin
      activeChan <= chanSel;
      activeSrc  <= srcSel;
    end
  end

  // --------------------------------------------------------------------------
  // Counters
  // --------------------------------------------------------------------------
  // Clearing at start, not at read, keeps the last result visible while idle
  rfc_edge_counter #(.W(`RFC_CYC_W)) u_cycle (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .sigIn    (selOsc),
    .clear    (startAccept),
    .enable   (inGate),
    .count    (cycleCount),
    .rise     (cycRise)
  );

  rfc_edge_counter #(.W(`RFC_REF_W)) u_ref (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .sigIn    (refOsc),
    .clear    (startAccept),
    .enable   (inGate),
    .count    (refCount),
    .rise     (refRise)
  );

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_chan_stable: assert property (
    measBusy && $past(measBusy) |-> $stable(activeChan) && $stable(activeSrc))
    else $error("Input selection changed during a measurement");

  a_gate_length: assert property (
    (inGate && next_state == RFC_HOLD) |-> gateTimer == GATE_LAST)
    else $error("Gate closed before its full length");

  a_cycle_inc: assert property (
    inGate && cycRise |=> cycleCount == `RFC_CYC_W'($past(cycleCount) + 1'b1))
    else $error("Input cycle not counted in gate");

  a_ref_inc: assert property (
    inGate && refRise |=> refCount == `RFC_REF_W'($past(refCount) + 1'b1))
    else $error("Reference cycle not counted in gate");

  a_rtc_source: assert property (
    startAccept && srcSel == RFC_SRC_RTC |=> ##1 (activeSrc == RFC_SRC_RTC) && selOsc == rtcOsc)
    else $error("Clock oscillator not selected for measurement");

  a_clear_start: assert property (
    startAccept |=> cycleCount == '0 && refCount == '0 && measBusy)
    else $error("Counters not cleared at start");

  a_hold_values: assert property (
    (state == RFC_HOLD) && !readAck |=> $stable(cycleCount) && $stable(refCount) && measDone)
    else $error("Counts changed before read");

  a_done_release: assert property (
    measDone && (state == RFC_HOLD) && readAck |=> !measDone ##1 !measDone || startReq)
    else $error("Done not released after read");

  a_arm_settle: assert property (
    (state == RFC_ARM) && !armSettled |=> state == RFC_ARM)
    else $error("Gate opened on the first armed cycle");

  a_busy_state: assert property (
    measBusy == is_busy(state))
    else $error("Busy flag out of step with the sequencer");

  a_done_state: assert property (
    measDone == (state == RFC_HOLD))
    else $error("Done flag out of step with the sequencer");

  a_gate_early: assert property (
    inGate && !gateExpired |=> inGate)
    else $error("Gate closed before the timer ran out");

  a_gate_start: assert property (
    gateOpen |=> inGate && gateTimer == '0 && cycleCount == '0)
    else $error("Gate did not open from zero");

  // Counts may move only inside the gate or on the clearing start edge
  a_count_frozen: assert property (
    !inGate && !startAccept |=> $stable(cycleCount) && $stable(refCount))
    else $error("Counts moved outside the gate");

  a_close_flags: assert property (
    gateClose |=> measDone && !measBusy)
    else $error("Gate close not reported");

  a_start_refused: assert property (
    (state == RFC_HOLD) && startReq && !readAck |=> state == RFC_HOLD)
    else $error("Start taken while results were held");

  a_read_clear: assert property (
    (state == RFC_HOLD) && readAck |=> (state == RFC_IDLE) && $stable(cycleCount))
    else $error("Read did not release the held counts");

endmodule

// ===== verif/rfc_osc_model.sv
// Free-running squared oscillator source, synchronous to the core clock
`timescale 1ns/1ps
module rfc_osc_model (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] halfCyc,
  output logic            osc
);
  logic [3:0] cnt;

  // Runs free between gates, as a real oscillator does
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 4'h0;
      osc <= 1'b0;
    end else if (cnt + 4'h1 >= halfCyc) begin
      cnt <= 4'h0;
      osc <= ~osc;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// ===== verif/reciprocal_frequency_counter_tb.sv
// Self-checking bench for the reciprocal frequency counter
`timescale 1ns/1ps
module reciprocal_frequency_counter_tb;
  import rfc_pkg::*;
  localparam int unsigned GATE = 50;
  localparam int HALF [6] = '{3, 4, 7, 9, 6, 1};
  logic        core_clk;
  logic        sys_rst;
  wire [5:0]   oscAll;
  logic [1:0]  chanSel;
  rfc_src_t    srcSel;
  logic        startReq;
  logic        readAck;
  logic [11:0] cycleCount;
  logic [19:0] refCount;
  logic        measBusy;
  logic        measDone;
  logic [1:0]  activeChan;
  rfc_src_t    activeSrc;
  int          failures;
  int          n_checks;

  for (genvar i = 0; i < 6; i++) begin : g_osc
    rfc_osc_model rfc_osc_model_i (.core_clk(core_clk), .sys_rst(sys_rst),
      .halfCyc(4'(HALF[i])), .osc(oscAll[i]));
  end

  rfc_freq_counter #(.GATE_CYCLES(GATE)) rfc_freq_counter_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .sensorOsc(oscAll[3:0]),
    .rtcOsc(oscAll[4]), .refOsc(oscAll[5]), .chanSel(chanSel), .srcSel(srcSel),
    .startReq(startReq), .readAck(readAck), .cycleCount(cycleCount),
    .refCount(refCount), .measBusy(measBusy), .measDone(measDone),
    .activeChan(activeChan), .activeSrc(activeSrc));

  task automatic check(string what, logic [19:0] seen, logic [19:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One gated measurement; the gate ends on the first input rise past GATE cycles
  task automatic measure(logic [1:0] ch, rfc_src_t src, int half);
    int p;
    int n;
    int k;
    p = 2 * half;
    n = (GATE + p - 1) / p;
    @(posedge core_clk);
    chanSel <= ch;
    srcSel <= src;
    startReq <= 1'b1;
    @(posedge core_clk);
    startReq <= 1'b0;
    chanSel <= ~ch;
    #1;
    check("busy", measBusy, 1'b1);
    check("cycles cleared", cycleCount, 20'h0);
    check("ref cleared", refCount, 20'h0);
    check("source", activeSrc, src);
    k = 0;
    // A start while busy or holding must be ignored
    while (measDone !== 1'b1 && k < 400) begin
      @(posedge core_clk);
      startReq <= 1'b1;
      #1;
      k++;
    end
    if (measDone !== 1'b1) begin
      failures++;
      test_done();
    end
    @(posedge core_clk);
    startReq <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    check("cycles", cycleCount, 20'(n));
    check("ref", refCount, 20'(n * p / 2));
    check("period", 20'(2 * HALF[5] * refCount / cycleCount), 20'(p));
    check("channel", activeChan, ch);
    check("done held", {measDone, measBusy}, 2'b10);
    @(posedge core_clk);
    readAck <= 1'b1;
    @(posedge core_clk);
    readAck <= 1'b0;
    #1;
    check("done cleared", measDone, 1'b0);
    check("cycles kept", cycleCount, 20'(n));
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    sys_rst = 1'b1;
    startReq = 1'b0;
    readAck = 1'b0;
    chanSel = 2'h0;
    srcSel = RFC_SRC_SENSOR;
    failures = 0;
    n_checks = 0;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      measure(2'(c), RFC_SRC_SENSOR, HALF[c]);
    end
    measure(2'h2, RFC_SRC_RTC, HALF[4]);
    test_done();
  end
endmodule
